// File: hw/board_io_pkg.sv
/*
 * Constants for the host I/O decode and line-direction glue of a two-port
 * serial plus parallel adapter card.
 * Assumes a byte-wide host I/O bus on one 100 MHz clock.
 */
// Summary of operation
// - The card decodes a contiguous twenty-byte host I/O window.
// - Window holds two eight-byte serial banks and a four-byte parallel bank.
// - Write to port-one offset seven loads transmit enables and receive disables.
// - Read of that offset gives port-two interrupt in bit 7, port-one in bit 6.
// - Same read returns both transmit enables in bits 0 and 1.
// - Interrupt status bit is 1 while its serial port requests an interrupt.
// - Terminal-ready is bit 0 of each port's modem control at offset four.
// - Terminal-ready 0 disables the line transmitter, 1 enables; resets to 0.
// - Terminal-ready also drives the UART terminal-ready output pin.
// - Receive-disable 0 lets reception through, 1 blocks it; resets to 0.
// - Receive-disable is bit 1 for port one, bit 3 for port two.
// - In RS-485 the transmit enable follows its board bit, whether or not the port is sending.
// - Serial offset zero reads received data and takes transmit data.
// - Port-two offset seven is a scratch byte returning the last write.
// - Parallel offset zero is read/write data; offset two reads control, takes commands.
package board_io_pkg;
    localparam logic [2:0] OFS_HOLDING   = 3'h0;
    localparam logic [2:0] OFS_IRQ_EN    = 3'h1;
    localparam logic [2:0] OFS_IRQ_ID    = 3'h2;
    localparam logic [2:0] OFS_LINE_CTL  = 3'h3;
    localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
    localparam logic [2:0] OFS_LINE_STAT = 3'h5;
    localparam logic [2:0] OFS_MODEM_ST  = 3'h6;
    localparam logic [2:0] OFS_BOARD     = 3'h7;
    localparam logic [1:0] OFS_PAR_DATA  = 2'h0;
    localparam logic [1:0] OFS_PAR_STAT  = 2'h1;
    localparam logic [1:0] OFS_PAR_CTL   = 2'h2;
    localparam int BOARD_TX1  = 0;
    localparam int BOARD_RXD1 = 1;
    localparam int BOARD_TX2  = 2;
    localparam int BOARD_RXD2 = 3;
    localparam int RD_TX1     = 0;
    localparam int RD_TX2     = 1;
    localparam int RD_IRQ1    = 6;
    localparam int RD_IRQ2    = 7;
    localparam int MCR_TERM_READY = 0;
    localparam int MCR_REQ_SEND   = 1;
    localparam int SERIAL_BANK_BYTES = 8;
    localparam int PAR_BANK_BYTES    = 4;
    localparam int WINDOW_BYTES      = 20;
    localparam int NUM_PORTS         = 2;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] BOARD_RESET = 4'h0;
endpackage : board_io_pkg

// File: hw/uart_regs_if.sv
/*
 * Interface carrying one serial port's register access and line state.
 * Assumes the glue top drives all request signals.
 */
interface uart_regs_if;
    logic       wrStrobe;
    logic       rdStrobe;
    logic [2:0] offset;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic [7:0] rxByte;
    logic       rxValid;
    logic [7:0] txByte;
    logic       txValid;
    logic       irqPending;
    logic       terminalReady;
    logic       requestSend;
    modport host (output wrStrobe, rdStrobe, offset, wrData, rxByte, rxValid,
                  input rdData, txByte, txValid, irqPending, terminalReady, requestSend);
    modport port (input wrStrobe, rdStrobe, offset, wrData, rxByte, rxValid,
                  output rdData, txByte, txValid, irqPending, terminalReady, requestSend);
endinterface : uart_regs_if

// File: hw/uart_reg_bank.sv
/*
 * Register bank of one serial port: holding, enable, identify, line and modem
 * control and status, plus an optional scratch byte at offset seven.
 * Assumes accesses are decoded by the glue top; no baud engine is modelled.
 */
module uart_reg_bank
    import board_io_pkg::*;
#(
    parameter bit HAS_SCRATCH = 1'b0
) (
    input  wire logic clock,   // System clock
    input  wire logic rst_n,   // Synchronous reset, active low
    uart_regs_if.port bus      // Register access and line state
);
    typedef struct packed {
        logic [7:0] rxHold;
        logic       rxFull;
        logic [7:0] txHold;
        logic       txValid;
        logic [7:0] irqEnable;
        logic [7:0] lineCtl;
        logic [7:0] modemCtl;
        logic [7:0] scratch;
        logic [7:0] rdData;
    } bank_t;
    bank_t cur;
    bank_t next_cur;
    logic [7:0] lineStat;
    logic [7:0] irqId;

    assign lineStat = {7'h00, cur.rxFull};
    // Only a receive-data interrupt is modelled; bit 0 low means pending.
    assign irqId = (cur.irqEnable[0] && cur.rxFull) ? 8'h04 : 8'h01;

    always_comb begin
        next_cur = cur;
        next_cur.txValid = 1'b0;
        if (bus.rxValid) begin
            next_cur.rxHold = bus.rxByte;
            next_cur.rxFull = 1'b1;
        end
        if (bus.wrStrobe) begin
            case (bus.offset)
                OFS_HOLDING: begin
                    next_cur.txHold  = bus.wrData;
                    next_cur.txValid = 1'b1;
                end
                OFS_IRQ_EN:    next_cur.irqEnable = bus.wrData;
                OFS_LINE_CTL:  next_cur.lineCtl   = bus.wrData;
                OFS_MODEM_CTL: next_cur.modemCtl  = bus.wrData;
                OFS_BOARD:     next_cur.scratch   = HAS_SCRATCH ? bus.wrData : cur.scratch;
                default:       next_cur.scratch   = cur.scratch;
            endcase
        end
        if (bus.rdStrobe) begin
            case (bus.offset)
                OFS_HOLDING: begin
                    next_cur.rdData = cur.rxHold;
                    // A new byte arriving with the read keeps the full flag set.
                    if (!bus.rxValid) begin
                        next_cur.rxFull = 1'b0;
                    end
                end
                OFS_IRQ_EN:    next_cur.rdData = cur.irqEnable;
                OFS_IRQ_ID:    next_cur.rdData = irqId;
                OFS_LINE_CTL:  next_cur.rdData = cur.lineCtl;
                OFS_MODEM_CTL: next_cur.rdData = cur.modemCtl;
                OFS_LINE_STAT: next_cur.rdData = lineStat;
                OFS_MODEM_ST:  next_cur.rdData = BYTE_RESET;
                OFS_BOARD:     next_cur.rdData = HAS_SCRATCH ? cur.scratch : BYTE_RESET;
                default:       next_cur.rdData = BYTE_RESET;
            endcase
        end
        if (!rst_n) begin
            next_cur = '0;
        end
    end

    always_ff @(posedge clock) begin
        cur <= next_cur;
    end

    assign bus.rdData        = cur.rdData;
    assign bus.txByte        = cur.txHold;
    assign bus.txValid       = cur.txValid;
    assign bus.irqPending    = cur.irqEnable[0] && cur.rxFull;
    assign bus.terminalReady = cur.modemCtl[MCR_TERM_READY];
    assign bus.requestSend   = cur.modemCtl[MCR_REQ_SEND];
endmodule : uart_reg_bank

// File: hw/board_io_glue.sv
/*
 * Host I/O decode and line-direction glue for a two-port serial plus
 * parallel adapter card. Three bank selects from the host's own decoder
 * cover the twenty-byte window; a byte offset picks the register.
 * Assumes host strobes are one-cycle pulses synchronous to clock.
 */
module board_io_glue
    import board_io_pkg::*;
(
    input  wire logic       clock,               // 100 MHz host clock
    input  wire logic       rst_n,               // Synchronous reset, active low
    input  wire logic       serial1Sel,          // Access hits serial1_bank_base
    input  wire logic       serial2Sel,          // Access hits serial2_bank_base
    input  wire logic       parallelSel,         // Access hits parallel bank
    input  wire logic [2:0] ioOffset,            // Byte offset within bank
    input  wire logic       ioWrite,             // Write strobe, one cycle
    input  wire logic       ioRead,              // Read strobe, one cycle
    input  wire logic [7:0] ioWrData,            // Write data
    output logic      [7:0] ioRdData,            // Read data, valid two cycles after read
    output logic            ioRdValid,           // Read data valid pulse
    input  wire logic [7:0] rxByte1,             // Received byte, port one
    input  wire logic       rxValid1,            // Received byte strobe, port one
    input  wire logic [7:0] rxByte2,             // Received byte, port two
    input  wire logic       rxValid2,            // Received byte strobe, port two
    output logic      [7:0] txByte1,             // Byte to send, port one
    output logic            txValid1,            // Send strobe, port one
    output logic      [7:0] txByte2,             // Byte to send, port two
    output logic            txValid2,            // Send strobe, port two
    output logic            terminal_ready_port1, // UART terminal-ready pin, port one
    output logic            terminal_ready_port2, // UART terminal-ready pin, port two
    output logic            request_send_port1,  // UART request-to-send pin, port one
    output logic            request_send_port2,  // UART request-to-send pin, port two
    output logic            rs422TxEn1,          // RS-422 line driver enable, port one
    output logic            rs422TxEn2,          // RS-422 line driver enable, port two
    output logic            rs485TxEn1,          // RS-485 driver enable, port one
    output logic            rs485TxEn2,          // RS-485 driver enable, port two
    output logic            rxDisable1,          // Receiver disable, port one
    output logic            rxDisable2,          // Receiver disable, port two
    output logic            irq_pending_port1,   // Interrupt request, port one
    output logic            irq_pending_port2,   // Interrupt request, port two
    input  wire logic [7:0] parallelIn,          // External parallel data pins
    output logic      [7:0] parallelOut,         // Parallel data output
    output logic      [7:0] parallelCtl          // Parallel control lines
);
    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [3:0] board;
        logic [7:0] parData;
        logic [7:0] parCtl;
        logic [7:0] rdData;
        logic       rdValid;
        logic       rdBank;
        logic [1:0] rdPort;
        logic [7:0] parIn1;
        logic [7:0] parIn2;
        logic [7:0] parIn3;
    } glue_t;
    glue_t cur;
    glue_t next_cur;

    uart_regs_if port1 ();
    uart_regs_if port2 ();

    // ==========================================================
    // Serial banks
    // ==========================================================
    logic hit1;
    logic hit2;
    logic hitP;
    logic board1Hit;
    assign hit1 = serial1Sel;
    assign hit2 = serial2Sel && !serial1Sel;
    assign hitP = parallelSel && !serial1Sel && !serial2Sel && (ioOffset < 3'(PAR_BANK_BYTES));
    // Port-one offset seven belongs to the glue, not to the UART.
    assign board1Hit = hit1 && (ioOffset == OFS_BOARD);

    assign port1.wrStrobe = ioWrite && hit1 && !board1Hit;
    assign port1.rdStrobe = ioRead && hit1 && !board1Hit;
    assign port1.offset   = ioOffset;
    assign port1.wrData   = ioWrData;
    assign port1.rxByte   = rxByte1;
    assign port1.rxValid  = rxValid1;
    assign port2.wrStrobe = ioWrite && hit2;
    assign port2.rdStrobe = ioRead && hit2;
    assign port2.offset   = ioOffset;
    assign port2.wrData   = ioWrData;
    assign port2.rxByte   = rxByte2;
    assign port2.rxValid  = rxValid2;

    uart_reg_bank #(.HAS_SCRATCH(1'b0)) bank1 (
        .clock (clock),
        .rst_n (rst_n),
        .bus   (port1.port)
    );
    uart_reg_bank #(.HAS_SCRATCH(1'b1)) bank2 (
        .clock (clock),
        .rst_n (rst_n),
        .bus   (port2.port)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        next_cur = cur;
        next_cur.rdValid  = 1'b0;
        // Three-stage capture of the external parallel pins.
        next_cur.parIn1 = parallelIn;
        next_cur.parIn2 = cur.parIn1;
        next_cur.parIn3 = cur.parIn2;
        if (ioWrite && board1Hit) begin
            next_cur.board = ioWrData[3:0];
        end
        if (ioWrite && hitP) begin
            case (ioOffset[1:0])
                OFS_PAR_DATA: next_cur.parData = ioWrData;
                OFS_PAR_CTL:  next_cur.parCtl  = ioWrData;
                default:      next_cur.parData = cur.parData;
            endcase
        end
        if (ioRead) begin
            next_cur.rdValid = 1'b1;
            next_cur.rdBank  = 1'b0;
            next_cur.rdPort  = 2'h0;
            next_cur.rdData  = BYTE_RESET;
            if (board1Hit) begin
                next_cur.rdData[RD_IRQ2] = port2.irqPending;
                next_cur.rdData[RD_IRQ1] = port1.irqPending;
                next_cur.rdData[RD_TX1]  = cur.board[BOARD_TX1];
                next_cur.rdData[RD_TX2]  = cur.board[BOARD_TX2];
            end else if (hit1) begin
                next_cur.rdBank = 1'b1;
                next_cur.rdPort = 2'h1;
            end else if (hit2) begin
                next_cur.rdBank = 1'b1;
                next_cur.rdPort = 2'h2;
            end else if (hitP) begin
                case (ioOffset[1:0])
                    // Pins agreeing on the last two stages count as settled.
                    OFS_PAR_DATA: next_cur.rdData = (cur.parIn2 == cur.parIn3)
                                                    ? cur.parIn3 : cur.parData;
                    OFS_PAR_STAT: next_cur.rdData = BYTE_RESET;
                    OFS_PAR_CTL:  next_cur.rdData = cur.parCtl;
                    default:      next_cur.rdData = BYTE_RESET;
                endcase
            end
        end
        if (!rst_n) begin
            next_cur = '0;
            next_cur.board = BOARD_RESET;
        end
    end

    always_ff @(posedge clock) begin
        cur <= next_cur;
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // UART banks register their read data, so the mux below is one flop deep
    // from the bank and the output flop aligns it with the glue's own reads.
    logic [7:0] rdMux;
    assign rdMux = !cur.rdBank ? cur.rdData
                 : (cur.rdPort == 2'h1) ? port1.rdData : port2.rdData;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ioRdData             <= BYTE_RESET;
            ioRdValid            <= 1'b0;
            txByte1              <= BYTE_RESET;
            txValid1             <= 1'b0;
            txByte2              <= BYTE_RESET;
            txValid2             <= 1'b0;
            terminal_ready_port1 <= 1'b0;
            terminal_ready_port2 <= 1'b0;
            request_send_port1   <= 1'b0;
            request_send_port2   <= 1'b0;
            rs422TxEn1           <= 1'b0;
            rs422TxEn2           <= 1'b0;
            rs485TxEn1           <= 1'b0;
            rs485TxEn2           <= 1'b0;
            rxDisable1           <= 1'b0;
            rxDisable2           <= 1'b0;
            irq_pending_port1    <= 1'b0;
            irq_pending_port2    <= 1'b0;
            parallelOut          <= BYTE_RESET;
            parallelCtl          <= BYTE_RESET;
        end else begin
            ioRdData             <= rdMux;
            ioRdValid            <= cur.rdValid;
            txByte1              <= port1.txByte;
            txValid1             <= port1.txValid;
            txByte2              <= port2.txByte;
            txValid2             <= port2.txValid;
            terminal_ready_port1 <= port1.terminalReady;
            terminal_ready_port2 <= port2.terminalReady;
            request_send_port1   <= port1.requestSend;
            request_send_port2   <= port2.requestSend;
            rs422TxEn1           <= port1.terminalReady;
            rs422TxEn2           <= port2.terminalReady;
            rs485TxEn1           <= cur.board[BOARD_TX1];
            rs485TxEn2           <= cur.board[BOARD_TX2];
            rxDisable1           <= cur.board[BOARD_RXD1];
            rxDisable2           <= cur.board[BOARD_RXD2];
            irq_pending_port1    <= port1.irqPending;
            irq_pending_port2    <= port2.irqPending;
            parallelOut          <= cur.parData;
            parallelCtl          <= cur.parCtl;
        end
    end
endmodule : board_io_glue

// File: dv/board_io_glue_chk.sv
/*
 * Concurrent checks on the ports of the board I/O glue top.
 * Assumes one clock domain and the two-cycle read and write latency.
 */
// ==============================================================
// Checker
module board_io_glue_chk
    import board_io_pkg::*;
(
    input wire logic       clock,                // System clock
    input wire logic       rst_n,                // Synchronous reset
    input wire logic       serial1Sel,           // Port-one bank select
    input wire logic       serial2Sel,           // Port-two bank select
    input wire logic       parallelSel,          // Parallel bank select
    input wire logic [2:0] ioOffset,             // Byte offset
    input wire logic       ioWrite,              // Write strobe
    input wire logic       ioRead,               // Read strobe
    input wire logic [7:0] ioWrData,             // Write data
    input wire logic [7:0] ioRdData,             // Read data
    input wire logic       ioRdValid,            // Read data valid
    input wire logic       terminal_ready_port1, // Terminal ready, one
    input wire logic       terminal_ready_port2, // Terminal ready, two
    input wire logic       rs422TxEn1,           // Line driver, one
    input wire logic       rs422TxEn2,           // Line driver, two
    input wire logic       rs485TxEn1,           // Bus driver, one
    input wire logic       rs485TxEn2,           // Bus driver, two
    input wire logic       rxDisable1,           // Receiver off, one
    input wire logic       rxDisable2            // Receiver off, two
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic boardWr;
    logic modemWr;
    logic modemBit;
    assign boardWr = ioWrite && serial1Sel && ioOffset == 3'h7;
    assign modemWr = ioWrite && serial1Sel && ioOffset == 3'h4;
    always_ff @(posedge clock) begin
        if (modemWr) begin
            modemBit <= ioWrData[0];
        end
    end
    a_reset_clear: assert property ($past(!rst_n) |-> !(rs485TxEn1 || rs485TxEn2 || rxDisable1
        || rxDisable2 || terminal_ready_port1)) else $error("outputs not cleared after reset");
    a_dir_one: assert property (boardWr |-> ##2 {rxDisable1, rs485TxEn1} == $past(ioWrData[1:0], 2))
        else $error("port one direction bits wrong");
    a_dir_two: assert property (boardWr |-> ##2 {rxDisable2, rs485TxEn2} == $past(ioWrData[3:2], 2))
        else $error("port two direction bits wrong");
    a_read_latency: assert property (ioRead && (serial1Sel || serial2Sel || parallelSel)
        |-> ##2 ioRdValid) else $error("read answer late");
    a_valid_cause: assert property (ioRdValid |-> $past(ioRead, 2))
        else $error("read valid without read");
    a_dir_readback: assert property (ioRead && serial1Sel && ioOffset == 3'h7 |->
        ##2 ioRdData[5:0] == {4'h0, rs485TxEn2, rs485TxEn1}) else $error("readback wrong");
    a_dtr_gate: assert property (rs422TxEn1 == terminal_ready_port1
        && rs422TxEn2 == terminal_ready_port2) else $error("line driver not tied to ready");
    a_modem_write: assert property (modemWr |-> ##[1:3] terminal_ready_port1 == modemBit)
        else $error("terminal ready not loaded");
    c_board_write: cover property (boardWr);
    c_irq_read: cover property (ioRdValid && ioRdData[6]);
    c_dtr_rise: cover property ($rose(terminal_ready_port1));
endmodule // board_io_glue_chk

bind board_io_glue board_io_glue_chk board_io_glue_chk_inst (.clock, .rst_n, .serial1Sel,
    .serial2Sel, .parallelSel, .ioOffset, .ioWrite, .ioRead, .ioWrData, .ioRdData, .ioRdValid,
    .terminal_ready_port1, .terminal_ready_port2, .rs422TxEn1, .rs422TxEn2, .rs485TxEn1,
    .rs485TxEn2, .rxDisable1, .rxDisable2);

// File: dv/host_bus_model.sv
/*
 * Host processor model issuing one byte access per call on the I/O bus.
 * Assumes the two-cycle read answer of the glue.
 */
// ==============================================================
// Host bus model
module host_bus_model (
    input  wire logic       clock,       // System clock
    input  wire logic [7:0] ioRdData,    // Read data
    input  wire logic       ioRdValid,   // Read data valid
    output logic            serial1Sel,  // Port-one bank select
    output logic            serial2Sel,  // Port-two bank select
    output logic            parallelSel, // Parallel bank select
    output logic      [2:0] ioOffset,    // Byte offset
    output logic            ioWrite,     // Write strobe
    output logic            ioRead,      // Read strobe
    output logic      [7:0] ioWrData     // Write data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {serial1Sel, serial2Sel, parallelSel, ioOffset, ioWrite, ioRead, ioWrData} = '0;
    // Released data and offset lines show inverted values so stale data is never mistaken for valid.
    task automatic cyc(input logic [1:0] bank, input logic [2:0] ofs, input logic wr,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        serial1Sel  <= bank == 2'd0;
        serial2Sel  <= bank == 2'd1;
        parallelSel <= bank == 2'd2;
        ioOffset    <= ofs;
        ioWrite     <= wr;
        ioRead      <= !wr;
        ioWrData    <= d;
        @(posedge clock);
        {serial1Sel, serial2Sel, parallelSel, ioWrite, ioRead} <= '0;
        ioWrData <= ~d;
        ioOffset <= ~ofs;
        q = 8'h00;
        if (!wr) begin
            repeat (2) @(posedge clock);
            q = (ioRdValid === 1'b1) ? ioRdData : 8'hxx;
        end
    endtask
endmodule // host_bus_model

// File: dv/dual_serial_board_io_glue_tb.sv
/*
 * Self-checking bench for the board I/O glue, driven through the host model.
 * Assumes the checker is bound to the glue top.
 */
// ==============================================================
// Bench top
module dual_serial_board_io_glue_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import board_io_pkg::*;
    logic       clock, rst_n, rxValid1, rxValid2, serial1Sel, serial2Sel, parallelSel;
    logic       ioWrite, ioRead, ioRdValid, txValid1, txValid2, terminal_ready_port1;
    logic       terminal_ready_port2, request_send_port1, request_send_port2, rs422TxEn1;
    logic       rs422TxEn2, rs485TxEn1, rs485TxEn2, rxDisable1, rxDisable2;
    logic       irq_pending_port1, irq_pending_port2;
    logic [2:0] ioOffset;
    logic [7:0] ioWrData, ioRdData, rxByte1, rxByte2, txByte1, txByte2;
    logic [7:0] parallelIn, parallelOut, parallelCtl;
    logic [7:0] txq1[$];
    logic [7:0] txq2[$];
    int         errTotal = 0;
    int         testsRun = 0;
    board_io_glue board_io_glue_inst (.clock, .rst_n, .serial1Sel, .serial2Sel, .parallelSel,
        .ioOffset, .ioWrite, .ioRead, .ioWrData, .ioRdData, .ioRdValid, .rxByte1, .rxValid1,
        .rxByte2, .rxValid2, .txByte1, .txValid1, .txByte2, .txValid2, .terminal_ready_port1,
        .terminal_ready_port2, .request_send_port1, .request_send_port2, .rs422TxEn1,
        .rs422TxEn2, .rs485TxEn1, .rs485TxEn2, .rxDisable1, .rxDisable2, .irq_pending_port1,
        .irq_pending_port2, .parallelIn, .parallelOut, .parallelCtl);
    host_bus_model host_bus_model_inst (.clock, .ioRdData, .ioRdValid, .serial1Sel,
        .serial2Sel, .parallelSel, .ioOffset, .ioWrite, .ioRead, .ioWrData);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (txValid1 === 1'b1) txq1.push_back(txByte1);
        if (txValid2 === 1'b1) txq2.push_back(txByte2);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int bank, input int ofs, input logic [7:0] d);
        logic [7:0] q;
        host_bus_model_inst.cyc(2'(bank), 3'(ofs), 1'b1, d, q);
    endtask
    task automatic rd(input int bank, input int ofs, output logic [7:0] q);
        host_bus_model_inst.cyc(2'(bank), 3'(ofs), 1'b0, 8'h00, q);
    endtask
    task automatic rdc(input int bank, input int ofs, input logic [7:0] exp);
        logic [7:0] q;
        rd(bank, ofs, q);
        chk(q, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic rx(input int p, input logic [7:0] b);
        @(posedge clock);
        if (p == 1) {rxByte2, rxValid2} <= {b, 1'b1};
        else {rxByte1, rxValid1} <= {b, 1'b1};
        @(posedge clock);
        {rxByte1, rxByte2, rxValid1, rxValid2} <= {~b, ~b, 2'b00};
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #200000;
        errTotal++;
        conclude();
    end
    initial begin
        int         brd, p;
        logic [7:0] b, m, pin;
        void'($urandom(32'h08e9));
        pin = 8'($urandom);
        {rst_n, rxValid1, rxValid2, rxByte1, rxByte2} = '0;
        parallelIn = pin;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1;
        chk({rxDisable2, rs485TxEn2, rxDisable1, rs485TxEn1, terminal_ready_port1,
             terminal_ready_port2, rs422TxEn1, rs422TxEn2}, 8'h00);
        rdc(0, 7, 8'h00);
        for (brd = 0; brd < 16; brd++) begin
            b = {4'($urandom), 4'(brd)};
            wr(0, 7, b);
            settle();
            chk({4'h0, rxDisable2, rs485TxEn2, rxDisable1, rs485TxEn1}, 8'(brd));
            rdc(0, 7, {6'h00, b[2], b[0]});
        end
        wr(0, 7, 8'h00);
        settle();
        chk({6'h00, rs485TxEn2, rs485TxEn1}, 8'h00);
        for (p = 0; p < 2; p++) begin
            b = {7'($urandom), 1'b0};
            wr(p, 4, b);
            rd(p, 4, m);
            chk(m, b);
            wr(p, 4, b | 8'h01);
            settle();
            chk({5'h00, (p == 1) ? {request_send_port2, terminal_ready_port2, rs422TxEn2}
                                 : {request_send_port1, terminal_ready_port1, rs422TxEn1}},
                {5'h00, b[1], 2'b11});
            rdc(p, 4, b | 8'h01);
            wr(p, 4, b & 8'hfe);
            settle();
            chk({7'h00, (p == 1) ? rs422TxEn2 : rs422TxEn1}, 8'h00);
            b = 8'($urandom) | 8'h01;
            wr(p, 0, b);
            settle();
            chk((p == 1) ? txq2.pop_front() : txq1.pop_front(), b);
            wr(p, 1, 8'h01);
            b = 8'($urandom);
            rx(p, b);
            settle();
            chk({6'h00, irq_pending_port2, irq_pending_port1}, (p == 1) ? 8'h02 : 8'h01);
            rdc(0, 7, (p == 1) ? 8'h80 : 8'h40);
            rdc(p, 0, b);
            settle();
            chk({6'h00, irq_pending_port2, irq_pending_port1}, 8'h00);
            rdc(0, 7, 8'h00);
        end
        chk(8'(txq1.size() + txq2.size()), 8'h00);
        b = 8'($urandom);
        wr(1, 7, b);
        wr(0, 7, 8'h00);
        rdc(1, 7, b);
        b = 8'($urandom);
        wr(2, 2, b);
        rdc(2, 2, b);
        chk(parallelCtl, b);
        wr(2, 0, ~pin);
        settle();
        chk(parallelOut, ~pin);
        rdc(2, 0, pin);
        rdc(2, 3, 8'h00);
        conclude();
    end
endmodule // dual_serial_board_io_glue_tb
